// File: hdl/meter_pkg.sv
// constants, register map and range tables of the measurement path
package meter_pkg;

	// ******************************
	// timing
	// ******************************
	localparam int CLK_HZ          = 25_000_000;
	localparam int HOLD_STEP_MS    = 100;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * HOLD_STEP_MS;
	localparam int TICK_W          = 22;

	// ******************************
	// register byte offsets
	// ******************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_SWING  = 8'h04;
	localparam logic [7:0] OFS_HOLD   = 8'h08;
	localparam logic [7:0] OFS_LOW_C  = 8'h0C;
	localparam logic [7:0] OFS_HIGH_C = 8'h10;
	localparam logic [7:0] OFS_EXT    = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_MASK   = 8'h1C;
	localparam logic [7:0] OFS_LIVE   = 8'h20;
	localparam logic [7:0] OFS_HELD   = 8'h24;
	localparam logic [7:0] OFS_NORM   = 8'h28;
	localparam logic [7:0] OFS_FLAGS  = 8'h2C;

	// ******************************
	// fields
	// ******************************
	localparam int CTRL_W       = 9;
	localparam int CTRL_SQUARE  = 3;
	localparam int CTRL_DROP    = 4;
	localparam int CTRL_DISP    = 5;
	localparam int CTRL_R1      = 6;
	localparam int CTRL_R2      = 7;
	localparam int CTRL_AOUT    = 8;
	localparam int EXT_HIGH_LSB = 16;
	localparam int IRQ_W        = 3;
	localparam int IRQ_PEAK     = 0;
	localparam int IRQ_ALARM    = 1;
	localparam int IRQ_EXPIRE   = 2;
	localparam int EXT_SCALE    = 1000;
	localparam logic [7:0] HOLD_MAX     = 8'h00_C7;
	localparam logic [9:0] EXT_LOW_MAX  = 10'h3_E7;
	localparam logic [9:0] EXT_HIGH_MAX = 10'h0_C7;

	// ******************************
	// reset values
	// ******************************
	localparam logic [15:0] LOW_C_RST  = 16'h0000;
	localparam logic [15:0] HIGH_C_RST = 16'h03E8;

	// ******************************
	// input ranges, sample in uA or mV
	// ******************************
	typedef enum logic [2:0] {RANGE_4_20, RANGE_0_20, RANGE_1_5, RANGE_0_5, RANGE_2_10, RANGE_0_10} range_e;
	localparam int RANGE_N = 6;
	localparam int RANGE_START [RANGE_N] = '{4000, 0, 1000, 0, 2000, 0};
	localparam int RANGE_WIDTH [RANGE_N] = '{16000, 20000, 4000, 5000, 8000, 10000};

	function automatic int recip_of(input int w);
		return int'(64'h0000_0001_0000_0000 / longint'(w));
	endfunction : recip_of

	localparam int RANGE_RECIP [RANGE_N] = '{recip_of(RANGE_WIDTH[0]), recip_of(RANGE_WIDTH[1]),
		recip_of(RANGE_WIDTH[2]), recip_of(RANGE_WIDTH[3]), recip_of(RANGE_WIDTH[4]),
		recip_of(RANGE_WIDTH[5])};

endpackage : meter_pkg

// File: hdl/measurement_peak_hold_scaler.sv
// measurement path: normalize, scale, peak hold, source routing, alarm
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module measurement_peak_hold_scaler import meter_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// measurement input
	input  wire logic [15:0] sample_i,
	input  wire logic        sample_valid_i,
	input  wire logic        cancel_key_i,
	// results
	output logic      [15:0] display_value_o,
	output logic      [15:0] relay_one_value_o,
	output logic      [15:0] relay_two_value_o,
	output logic      [15:0] analog_out_value_o,
	output logic             alarm_lamp_o,
	output logic             irq_o
);

	// ******************************
	// state
	// ******************************
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [15:0]       min_swing;
		logic [7:0]        hold_time;
		logic [15:0]       scale_low_coef;
		logic [15:0]       scale_high_coef;
		logic [9:0]        range_low_extension;
		logic [9:0]        range_high_extension;
		logic [IRQ_W-1:0]  status;
		logic [IRQ_W-1:0]  mask;
		logic [15:0]       live;
		logic [15:0]       track;
		logic [15:0]       peak;
		logic [31:0]       norm;
		logic              held_valid;
		logic              alarm;
		logic [TICK_W-1:0] tick_cnt;
		logic [7:0]        hold_cnt;
		logic [15:0]       disp;
		logic [15:0]       rel1;
		logic [15:0]       rel2;
		logic [15:0]       aout;
		logic              ack;
		logic [31:0]       dat;
		logic              irq;
	} state_s;

	state_s st;
	state_s next_st;

	// ******************************
	// helpers
	// ******************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh0000_7FFF) begin
			return 16'h7FFF;
		end else if (v < -32'sh0000_8000) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction : sat16

	// ******************************
	// normalize and scale
	// ******************************
	int                 idx;
	logic signed [16:0] diff;
	logic signed [47:0] prod_norm;
	logic signed [31:0] norm_now;
	logic signed [47:0] prod_sq;
	logic signed [31:0] shaped;
	logic signed [16:0] span;
	logic signed [47:0] prod_w;
	logic signed [31:0] w_sum;
	logic [15:0]        live_now;
	logic signed [31:0] x_scaled;
	logic signed [31:0] lo_bound;
	logic signed [31:0] hi_bound;
	logic               alarm_now;

	assign idx       = (int'(st.ctrl[2:0]) < RANGE_N) ? int'(st.ctrl[2:0]) : int'(RANGE_4_20);
	assign diff      = $signed({sample_i[15], sample_i}) - 17'(RANGE_START[idx]);
	assign prod_norm = $signed({{31{diff[16]}}, diff}) * $signed({16'h0000, 32'(RANGE_RECIP[idx])});
	assign norm_now  = prod_norm[47:16];
	assign prod_sq   = $signed({{16{norm_now[31]}}, norm_now}) * $signed({{16{norm_now[31]}}, norm_now});
	assign shaped    = st.ctrl[CTRL_SQUARE] ? prod_sq[47:16] : norm_now;
	assign span      = $signed({st.scale_high_coef[15], st.scale_high_coef})
		- $signed({st.scale_low_coef[15], st.scale_low_coef});
	assign prod_w    = $signed({{16{shaped[31]}}, shaped}) * $signed({{31{span[16]}}, span});
	assign w_sum     = prod_w[47:16] + $signed({{16{st.scale_low_coef[15]}}, st.scale_low_coef});
	assign live_now  = sat16(w_sum);

	// permissible range compared in thousandths, avoiding a divider
	assign x_scaled  = $signed({{16{sample_i[15]}}, sample_i}) * 32'sd1000;
	assign lo_bound  = 32'(RANGE_START[idx] * (EXT_SCALE - int'(st.range_low_extension)));
	assign hi_bound  = 32'((RANGE_START[idx] + RANGE_WIDTH[idx]) * (EXT_SCALE + int'(st.range_high_extension)));
	assign alarm_now = (x_scaled < lo_bound) || (x_scaled > hi_bound);

	// ******************************
	// next state
	// ******************************
	logic               req;
	logic [7:0]         wadr;
	logic [IRQ_W-1:0]   events;
	logic signed [17:0] swing_diff;
	logic               capture;
	logic               hold_en;
	logic [15:0]        held_now;
	logic [31:0]        wd;

	always_comb begin
		next_st    = st;
		req        = cyc_i && stb_i && !st.ack;
		wadr       = {adr_i[7:2], 2'b00};
		events     = '0;
		capture    = 1'b0;
		swing_diff = '0;
		wd         = 32'h0000_0000;
		hold_en    = (st.hold_time != 8'h00) || st.ctrl[CTRL_DISP];

		// hold timer
		if (st.held_valid && st.hold_time != 8'h00) begin
			if (st.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
				next_st.tick_cnt = '0;
				next_st.hold_cnt = st.hold_cnt + 8'h01;
				if (st.hold_cnt + 8'h01 >= st.hold_time) begin
					next_st.held_valid = 1'b0;
					events[IRQ_EXPIRE] = 1'b1;
				end
			end else begin
				next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
			end
		end
		if (cancel_key_i) begin
			next_st.held_valid = 1'b0;
		end
		if (!hold_en) begin
			next_st.held_valid = 1'b0;
		end

		// sample processing and extreme tracking
		if (sample_valid_i) begin
			next_st.live  = live_now;
			next_st.norm  = norm_now;
			next_st.alarm = alarm_now;
			if (alarm_now && !st.alarm) begin
				events[IRQ_ALARM] = 1'b1;
			end
			if (!st.ctrl[CTRL_DROP]) begin
				swing_diff = $signed({{2{st.track[15]}}, st.track}) - $signed({{2{live_now[15]}}, live_now});
				if ($signed(live_now) > $signed(st.track)) begin
					next_st.track = live_now;
				end else if (swing_diff >= $signed({2'b00, st.min_swing})) begin
					capture = 1'b1;
				end
			end else begin
				swing_diff = $signed({{2{live_now[15]}}, live_now}) - $signed({{2{st.track[15]}}, st.track});
				if ($signed(live_now) < $signed(st.track)) begin
					next_st.track = live_now;
				end else if (swing_diff >= $signed({2'b00, st.min_swing})) begin
					capture = 1'b1;
				end
			end
			if (capture) begin
				next_st.track     = live_now;
				events[IRQ_PEAK]  = 1'b1;
				if (hold_en) begin
					next_st.peak       = st.track;
					next_st.held_valid = 1'b1;
					next_st.tick_cnt   = '0;
					next_st.hold_cnt   = 8'h00;
				end
			end
		end

		// source routing
		held_now     = st.held_valid ? st.peak : st.live;
		next_st.disp = st.ctrl[CTRL_DISP] ? held_now : st.live;
		next_st.rel1 = st.ctrl[CTRL_R1] ? held_now : st.live;
		next_st.rel2 = st.ctrl[CTRL_R2] ? held_now : st.live;
		next_st.aout = st.ctrl[CTRL_AOUT] ? held_now : st.live;

		// bus slave
		next_st.ack = req;
		next_st.dat = 32'h0000_0000;
		if (req && we_i) begin
			unique case (wadr)
				OFS_CTRL: begin
					wd           = merge(32'(st.ctrl), dat_i, sel_i);
					next_st.ctrl = wd[CTRL_W-1:0];
				end
				OFS_SWING: begin
					wd                = merge(32'(st.min_swing), dat_i, sel_i);
					next_st.min_swing = wd[15:0];
				end
				OFS_HOLD: begin
					wd                = merge(32'(st.hold_time), dat_i, sel_i);
					next_st.hold_time = (wd[31:8] != 24'h0000_00 || wd[7:0] > HOLD_MAX) ? HOLD_MAX : wd[7:0];
				end
				OFS_LOW_C: begin
					wd                     = merge(32'(st.scale_low_coef), dat_i, sel_i);
					next_st.scale_low_coef = wd[15:0];
				end
				OFS_HIGH_C: begin
					wd                      = merge(32'(st.scale_high_coef), dat_i, sel_i);
					next_st.scale_high_coef = wd[15:0];
				end
				OFS_EXT: begin
					wd = merge({6'h00, st.range_high_extension, 6'h00, st.range_low_extension}, dat_i, sel_i);
					next_st.range_low_extension  = (wd[9:0] > EXT_LOW_MAX) ? EXT_LOW_MAX : wd[9:0];
					next_st.range_high_extension = (wd[EXT_HIGH_LSB +: 10] > EXT_HIGH_MAX) ? EXT_HIGH_MAX
						: wd[EXT_HIGH_LSB +: 10];
				end
				OFS_MASK: begin
					wd           = merge(32'(st.mask), dat_i, sel_i);
					next_st.mask = wd[IRQ_W-1:0];
				end
				default: begin
					wd = 32'h0000_0000;
				end
			endcase
		end
		next_st.status = st.status;
		if (req && !we_i) begin
			unique case (wadr)
				OFS_CTRL:   next_st.dat = 32'(st.ctrl);
				OFS_SWING:  next_st.dat = 32'(st.min_swing);
				OFS_HOLD:   next_st.dat = 32'(st.hold_time);
				OFS_LOW_C:  next_st.dat = 32'(st.scale_low_coef);
				OFS_HIGH_C: next_st.dat = 32'(st.scale_high_coef);
				OFS_EXT:    next_st.dat = {6'h00, st.range_high_extension, 6'h00, st.range_low_extension};
				OFS_STATUS: begin
					next_st.dat    = 32'(st.status);
					next_st.status = '0;
				end
				OFS_MASK:   next_st.dat = 32'(st.mask);
				OFS_LIVE:   next_st.dat = 32'(st.live);
				OFS_HELD:   next_st.dat = 32'(held_now);
				OFS_NORM:   next_st.dat = st.norm;
				OFS_FLAGS:  next_st.dat = {30'h0000_0000, st.held_valid, st.alarm};
				default:    next_st.dat = 32'h0000_0000;
			endcase
		end
		// set wins over the read clear
		next_st.status = next_st.status | events;
		next_st.irq    = |(next_st.status & st.mask);
	end

	// ******************************
	// registers
	// ******************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st                 <= '0;
			st.scale_low_coef  <= LOW_C_RST;
			st.scale_high_coef <= HIGH_C_RST;
		end else begin
			st <= next_st;
		end
	end

	assign dat_o              = st.dat;
	assign ack_o              = st.ack;
	assign display_value_o    = st.disp;
	assign relay_one_value_o  = st.rel1;
	assign relay_two_value_o  = st.rel2;
	assign analog_out_value_o = st.aout;
	assign alarm_lamp_o       = st.alarm;
	assign irq_o              = st.irq;

endmodule : measurement_peak_hold_scaler

`default_nettype wire

// File: verification/meter_checker_assertions.sv
// port-level assertion checker for the measurement path
`timescale 1ns/1ps
`default_nettype none
module meter_checker import meter_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// wishbone
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// measurement
	input wire logic [15:0] sample_i,
	input wire logic        sample_valid_i,
	input wire logic        alarm_lamp_o,
	input wire logic        irq_o
);
	// ********
	// assertions
	// ********
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
	a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
	a_data_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000) else $error("data outside ack");
	a_alarm_on_sample: assert property (!sample_valid_i |=> $stable(alarm_lamp_o))
		else $error("alarm moved without sample");
	a_alarm_negative: assert property (sample_valid_i && sample_i[15] |=> alarm_lamp_o)
		else $error("negative input not alarmed");
	a_alarm_high: assert property (sample_valid_i && !sample_i[15] && sample_i > 16'h5DC0 |=> alarm_lamp_o)
		else $error("high input not alarmed");
	a_alarm_inside: assert property (sample_valid_i && sample_i >= 16'h0FA0 && sample_i <= 16'h1388 |=> !alarm_lamp_o)
		else $error("nominal input alarmed");
	a_irq_clear_cause: assert property ($fell(irq_o) |-> ack_o || $past(ack_o)) else $error("irq dropped without access");
	c_irq: cover property ($rose(irq_o));
	c_alarm: cover property ($rose(alarm_lamp_o));
	c_read: cover property (ack_o && dat_o != 32'h0000_0000);
endmodule : meter_checker
bind measurement_peak_hold_scaler meter_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .sample_i(sample_i),
	.sample_valid_i(sample_valid_i), .alarm_lamp_o(alarm_lamp_o), .irq_o(irq_o));
`default_nettype wire

// File: verification/analog_source.sv
// far-side model: converter delivering one sample per command
`timescale 1ns/1ps
`default_nettype none
module analog_source (
	// clock
	input  wire logic        clk_i,
	// command
	input  wire logic        strobe_i,
	input  wire logic [15:0] value_i,
	// sample
	output logic      [15:0] sample_o,
	output logic             valid_o
);
	initial begin
		sample_o = 16'h0000;
		valid_o  = 1'b0;
	end
	// outside a sample the data lines toggle
	always @(posedge clk_i) begin
		valid_o  <= strobe_i;
		sample_o <= strobe_i ? value_i : ~sample_o;
	end
endmodule : analog_source
`default_nettype wire

// File: verification/measurement_peak_hold_scaler_test.sv
// self-checking bench for the measurement path
`timescale 1ns/1ps
`default_nettype none
module measurement_peak_hold_scaler_test import meter_pkg::*;;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, cancel = 1'b0, strobe = 1'b0, ack, sv, alarm, irq;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000, rdat, rd_q;
	logic [15:0] value = 16'h0000, smp, disp, r1, r2, aout;
	int          error_cnt = 0, num_checks = 0, cycles = 0;
	always #20 clk_i = ~clk_i;
	measurement_peak_hold_scaler #(.TICK_CYCLES(10)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .sample_i(smp),
		.sample_valid_i(sv), .cancel_key_i(cancel), .display_value_o(disp), .relay_one_value_o(r1),
		.relay_two_value_o(r2), .analog_out_value_o(aout), .alarm_lamp_o(alarm), .irq_o(irq));
	analog_source src (.clk_i(clk_i), .strobe_i(strobe), .value_i(value), .sample_o(smp), .valid_o(sv));
	// ********
	// helpers
	// ********
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			error_cnt++;
			results();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [15:0] calc(input int x, input int r, input logic sq, input int lo, input int hi);
		longint f;
		f = (longint'(x - RANGE_START[r]) * (longint'(64'h0000_0001_0000_0000) / RANGE_WIDTH[r])) >>> 16;
		if (sq)
			f = (f * f) >>> 16;
		f = ((f * (hi - lo)) >>> 16) + lo;
		return f[15:0];
	endfunction : calc
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
		rd_q = rdat;
		{cyc, stb} <= 2'b00;
		if (n >= 50)
			check(32'h0000_0000, 32'h0000_0001);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		check(rd_q, e);
	endtask : rd
	task automatic put(input int x);
		@(posedge clk_i);
		{strobe, value} <= {1'b1, 16'(x)};
		@(posedge clk_i);
		strobe <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : put
	// ********
	// scenarios
	// ********
	task automatic t_scale();
		rd(OFS_HIGH_C, {16'h0000, HIGH_C_RST});
		rd(8'h30, 32'h0000_0000);
		wr(OFS_LOW_C, 32'h0000_FED4);
		wr(OFS_HIGH_C, 32'h0000_04B0);
		wr(OFS_EXT, 32'h0064_012C);
		for (int i = 0; i < RANGE_N * 4; i++) begin
			int r = i / 4;
			int x = RANGE_START[r] + RANGE_WIDTH[r] * (i[0] ? 17 : 6) / 16;
			wr(OFS_CTRL, 32'(r + 8 * i[1]));
			put(x);
			check(disp, calc(x, r, i[1], -300, 1200));
		end
		wr(OFS_CTRL, 32'h0000_0007);
		put(10000);
		check(disp, calc(10000, 0, 1'b0, -300, 1200));
		wr(OFS_LOW_C, 32'h0000_03E8);
		wr(OFS_HIGH_C, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0000);
		put(10000);
		check(disp, calc(10000, 0, 1'b0, 1000, 0));
		$display("scale test done");
	endtask : t_scale
	task automatic t_alarm();
		int xs [7] = '{3199, 3200, 22000, 22001, -1, 25000, 4500};
		logic ex [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		wr(OFS_EXT, 32'h0064_00C8);
		wr(OFS_MASK, 32'h0000_0002);
		for (int i = 0; i < 7; i++) begin
			put(xs[i]);
			check(32'(alarm), 32'(ex[i]));
		end
		put(3000);
		check(32'(irq), 32'h0000_0001);
		wb(1'b0, OFS_STATUS, 32'h0000_0000);
		check(32'(rd_q[IRQ_ALARM]), 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check(32'(irq), 32'h0000_0000);
		wr(OFS_MASK, 32'h0000_0000);
		put(4500);
		put(3000);
		check(32'(irq), 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0001);
		put(100);
		check(32'(alarm), 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0000);
		$display("alarm test done");
	endtask : t_alarm
	task automatic t_peak();
		wr(OFS_LOW_C, 32'h0000_0000);
		wr(OFS_HIGH_C, 32'h0000_03E8);
		wr(OFS_SWING, 32'h0000_0064);
		// settle the tracked extreme on the new scale before holding is enabled
		put(8000);
		wr(OFS_HOLD, 32'h0000_00FF);
		rd(OFS_HOLD, {24'h00_0000, HOLD_MAX});
		wr(OFS_HOLD, 32'h0000_0002);
		wr(OFS_CTRL, 32'h0000_0160);
		put(16000);
		put(15000);
		check(disp, calc(15000, 0, 1'b0, 0, 1000));
		put(12000);
		check(disp, calc(16000, 0, 1'b0, 0, 1000));
		check(r1, calc(16000, 0, 1'b0, 0, 1000));
		check(r2, calc(12000, 0, 1'b0, 0, 1000));
		check(aout, calc(16000, 0, 1'b0, 0, 1000));
		repeat (30) @(posedge clk_i);
		check(disp, calc(12000, 0, 1'b0, 0, 1000));
		wb(1'b0, OFS_STATUS, 32'h0000_0000);
		check(32'(rd_q[IRQ_EXPIRE]), 32'h0000_0001);
		$display("peak test done");
	endtask : t_peak
	task automatic t_drop();
		wr(OFS_HOLD, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0030);
		put(16000);
		put(8000);
		put(9000);
		put(12000);
		check(disp, calc(8000, 0, 1'b0, 0, 1000));
		check(r2, calc(12000, 0, 1'b0, 0, 1000));
		repeat (40) @(posedge clk_i);
		check(disp, calc(8000, 0, 1'b0, 0, 1000));
		cancel <= 1'b1;
		@(posedge clk_i);
		cancel <= 1'b0;
		repeat (3) @(posedge clk_i);
		check(disp, calc(12000, 0, 1'b0, 0, 1000));
		$display("drop test done");
	endtask : t_drop
	task automatic t_live();
		wr(OFS_CTRL, 32'h0000_0000);
		put(8000);
		put(16000);
		put(12000);
		check(disp, calc(12000, 0, 1'b0, 0, 1000));
		rd(OFS_HELD, {16'h0000, calc(12000, 0, 1'b0, 0, 1000)});
		$display("live test done");
	endtask : t_live
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_scale();
		t_alarm();
		t_peak();
		t_drop();
		t_live();
		results();
	end
endmodule : measurement_peak_hold_scaler_test
`default_nettype wire
